/* src/pdma_host_end.sv */
// Purpose: Software and application-block end facing the packet_mover
//          channel control.
// Assumes: User commands arrive one at a time on cmd_valid and cmd_ready.
// Notes:   Commands that would break the usage rules are held back.
`timescale 1ns/1ps
module pdma_host_end
  import pdma_pkg::*;
#(
  parameter int NCH = DEF_NCH,
  parameter int CHW = (NCH > 1) ? $clog2(NCH) : 1
)(
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  pdma_link_if.host              lnk,
  input  wire logic              cmd_valid,
  input  wire cmd_op_e           cmd_op,
  input  wire logic [CHW-1:0]    cmd_chan,
  input  wire logic [DATA_W-1:0] cmd_data,
  input  wire logic              tx_idle,
  output      logic              cmd_ready,
  output      logic              rsp_valid,
  output      logic [DATA_W-1:0] rsp_data,
  input  wire logic              src_valid,
  input  wire logic [DATA_W-1:0] src_data,
  input  wire logic              src_sop,
  input  wire logic              src_eop,
  input  wire logic [CHW-1:0]    src_chan,
  output      logic              src_ready
);

  typedef struct packed {
    host_st_e          st;
    logic              init;
    logic              rdy;
    logic              rv;
    logic [DATA_W-1:0] rd;
    logic              req;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wd;
    logic              tdr;
    logic [CHW-1:0]    tdc;
    logic              sv;
    logic [DATA_W-1:0] sd;
    logic              ssop;
    logic              seop;
    logic [CHW-1:0]    sc;
    logic              srdy;
    logic [NCH-1:0]    inpkt;
    logic [NCH-1:0]    mono;
    logic              dv;
    logic [CHW-1:0]    dc;
    logic [SIZE_W-1:0] ds;
    logic [OFF_W-1:0]  doff;
  } host_s;

  host_s st_r;
  host_s st_nxt;

  logic              take;
  logic              allow;
  logic [ADDR_W-1:0] a_rx;
  logic [ADDR_W-1:0] a_tx;

  assign take = st_r.sv && lnk.rx_open[st_r.sc];

  always_comb begin
    a_rx = '0;
    a_rx[CH_SLOT_SHIFT +: CHW] = cmd_chan;
    a_rx[WORD_SEL_W-1:0] = RX_RUN_OFF;
    a_tx = a_rx;
    a_tx[WORD_SEL_W-1:0] = TX_MODE_OFF;
    a_tx[TX_REGION_BIT] = 1'b1;
  end

  // Hold disable until packet ends; mode writes need an idle channel
  assign allow = !((cmd_op == OP_INIT
                    || (cmd_op == OP_WRITE && !cmd_data[RX_EN_BIT]))
                   && st_r.inpkt[cmd_chan])
                 && !(cmd_op == OP_TXMODE && !tx_idle);

  always_comb begin
    st_nxt     = st_r;
    st_nxt.rv  = 1'b0;
    st_nxt.req = 1'b0;
    st_nxt.tdr = 1'b0;
    st_nxt.dv  = 1'b0;

    // One-beat source register
    if (take) begin
      st_nxt.sv = 1'b0;
      st_nxt.inpkt[st_r.sc] = !st_r.seop;
    end
    if (src_valid && st_r.srdy) begin
      st_nxt.sv   = 1'b1;
      st_nxt.sd   = src_data;
      st_nxt.ssop = src_sop;
      st_nxt.seop = src_eop;
      st_nxt.sc   = src_chan;
    end
    st_nxt.srdy = !st_nxt.sv;

    case (st_r.st)
      H_IDLE: begin
        if (cmd_valid && st_r.rdy && allow) begin
          st_nxt.init = 1'b0;
          st_nxt.addr = a_rx;
          st_nxt.we   = 1'b1;
          st_nxt.wd   = REG_RESET;
          case (cmd_op)
            OP_READ: begin
              st_nxt.we  = 1'b0;
              st_nxt.req = 1'b1;
              st_nxt.st  = H_BUSY;
            end
            OP_WRITE: begin
              st_nxt.wd  = cmd_data;
              st_nxt.req = 1'b1;
              st_nxt.st  = H_BUSY;
            end
            OP_INIT: begin
              // First write clears teardown with enable still low
              st_nxt.wd[RX_PA_BIT] = cmd_data[RX_PA_BIT];
              st_nxt.init = 1'b1;
              st_nxt.req  = 1'b1;
              st_nxt.st   = H_BUSY;
            end
            OP_TXMODE: begin
              st_nxt.addr = a_tx;
              st_nxt.wd[TX_MONO_BIT] = cmd_data[TX_MONO_BIT];
              st_nxt.mono[cmd_chan]  = cmd_data[TX_MONO_BIT];
              st_nxt.req  = 1'b1;
              st_nxt.st   = H_BUSY;
            end
            OP_TEARDOWN: begin
              st_nxt.tdr = 1'b1;
              st_nxt.tdc = cmd_chan;
              st_nxt.rv  = 1'b1;
              st_nxt.rd  = REG_RESET;
            end
            OP_TXDESC: begin
              st_nxt.dv   = 1'b1;
              st_nxt.dc   = cmd_chan;
              st_nxt.doff = cmd_data[OFF_W-1:0];
              st_nxt.ds   = st_r.mono[cmd_chan] ? FIX_DESC_SIZE
                                                : cmd_data[SIZE_W-1:0];
              st_nxt.rv   = 1'b1;
              st_nxt.rd   = REG_RESET;
            end
            default: begin
              st_nxt.rv = 1'b1;
              st_nxt.rd = REG_RESET;
            end
          endcase
        end
      end
      H_BUSY: begin
        if (lnk.reg_ack) begin
          if (st_r.init) begin
            // Second write sets enable after all fields are set
            st_nxt.wd[RX_EN_BIT] = 1'b1;
            st_nxt.req = 1'b1;
            st_nxt.st  = H_PHASE2;
          end else begin
            st_nxt.rv = 1'b1;
            st_nxt.rd = lnk.reg_rdata;
            st_nxt.st = H_IDLE;
          end
        end
      end
      H_PHASE2: begin
        if (lnk.reg_ack) begin
          st_nxt.rv = 1'b1;
          st_nxt.rd = lnk.reg_rdata;
          st_nxt.st = H_IDLE;
        end
      end
      default: begin
        st_nxt.st = H_IDLE;
      end
    endcase
    st_nxt.rdy = (st_nxt.st == H_IDLE) && !st_nxt.rv;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.reg_req       = st_r.req;
  assign lnk.reg_we        = st_r.we;
  assign lnk.reg_addr      = st_r.addr;
  assign lnk.reg_wdata     = st_r.wd;
  assign lnk.td_req        = st_r.tdr;
  assign lnk.td_chan       = st_r.tdc;
  assign lnk.rxs_valid     = st_r.sv;
  assign lnk.rxs_data      = st_r.sd;
  assign lnk.rxs_sop       = st_r.ssop;
  assign lnk.rxs_eop       = st_r.seop;
  assign lnk.rxs_chan      = st_r.sc;
  assign lnk.tx_desc_valid = st_r.dv;
  assign lnk.tx_desc_chan  = st_r.dc;
  assign lnk.tx_desc_size  = st_r.ds;
  assign lnk.tx_desc_off   = st_r.doff;

  assign cmd_ready = st_r.rdy;
  assign rsp_valid = st_r.rv;
  assign rsp_data  = st_r.rd;
  assign src_ready = st_r.srdy;

endmodule

/* src/pdma_link_if.sv */
// Purpose: Joins the packet_mover channel control and its outside party.
// Assumes: One clock for both ends.
// Notes:   Stream beats are taken when rxs_valid and rx_open[rxs_chan].
`timescale 1ns/1ps
interface pdma_link_if
  import pdma_pkg::*;
#(
  parameter int NCH = DEF_NCH,
  parameter int CHW = (NCH > 1) ? $clog2(NCH) : 1
);
  // Register port
  logic              reg_req;
  logic              reg_we;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_ack;
  logic [DATA_W-1:0] reg_rdata;
  // Teardown request
  logic              td_req;
  logic [CHW-1:0]    td_chan;
  // Receive stream from the application block
  logic              rxs_valid;
  logic [DATA_W-1:0] rxs_data;
  logic              rxs_sop;
  logic              rxs_eop;
  logic [CHW-1:0]    rxs_chan;
  logic [NCH-1:0]    rx_open;
  // Transmit monolithic descriptor push
  logic              tx_desc_valid;
  logic [CHW-1:0]    tx_desc_chan;
  logic [SIZE_W-1:0] tx_desc_size;
  logic [OFF_W-1:0]  tx_desc_off;

  modport dev (
    input  reg_req, reg_we, reg_addr, reg_wdata, td_req, td_chan,
    input  rxs_valid, rxs_data, rxs_sop, rxs_eop, rxs_chan,
    input  tx_desc_valid, tx_desc_chan, tx_desc_size, tx_desc_off,
    output reg_ack, reg_rdata, rx_open
  );

  modport host (
    output reg_req, reg_we, reg_addr, reg_wdata, td_req, td_chan,
    output rxs_valid, rxs_data, rxs_sop, rxs_eop, rxs_chan,
    output tx_desc_valid, tx_desc_chan, tx_desc_size, tx_desc_off,
    input  reg_ack, reg_rdata, rx_open
  );

endinterface

/* src/pdma_pkg.sv */
// Purpose: Shared constants and types for the packet_mover receive channel
//          control and its attached source/software end.
// Assumes: 32-bit register words, one register per 32-byte channel slot.
// Notes:   Transmit mode words sit in a second region selected by one
//          address bit.
package pdma_pkg;

  localparam int DATA_W        = 32;
  localparam int ADDR_W        = 12;
  localparam int DEF_NCH       = 8;
  localparam int OFF_W         = 9;
  localparam int SIZE_W        = 3;
  localparam int HDR_W         = 3;

  // Field positions
  localparam int RX_EN_BIT     = 31;
  localparam int RX_TD_BIT     = 30;
  localparam int RX_PA_BIT     = 29;
  localparam int TX_MONO_BIT   = 24;

  // Address layout
  localparam int CH_SLOT_SHIFT = 5;
  localparam int WORD_SEL_W    = 5;
  localparam int TX_REGION_BIT = 11;
  localparam logic [WORD_SEL_W-1:0] RX_RUN_OFF  = 5'h00;
  localparam logic [WORD_SEL_W-1:0] TX_MODE_OFF = 5'h04;

  localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

  // Monolithic header layouts
  localparam logic [HDR_W-1:0]  FIX_HDR_WORDS  = 3'h4;
  localparam logic [HDR_W-1:0]  NORM_HDR_WORDS = 3'h3;
  localparam logic [OFF_W-1:0]  FIX_DATA_OFF   = 9'h010;
  localparam logic [SIZE_W-1:0] FIX_DESC_SIZE  = 3'h3;

  typedef enum logic [2:0] {
    OP_READ     = 3'h0,
    OP_WRITE    = 3'h1,
    OP_INIT     = 3'h2,
    OP_TEARDOWN = 3'h3,
    OP_TXMODE   = 3'h4,
    OP_TXDESC   = 3'h5
  } cmd_op_e;

  typedef enum logic [1:0] {
    H_IDLE   = 2'b00,
    H_BUSY   = 2'b01,
    H_PHASE2 = 2'b11
  } host_st_e;

endpackage

/* src/pdma_rx_ctrl.sv */
// Purpose: Receive channel run control and transmit monolithic layout
//          select of the packet_mover.
// Assumes: The outside party holds a stream beat on a closed channel until it opens.
// Notes:   One stream beat is one block transfer.
`timescale 1ns/1ps

module pdma_rx_ctrl
  import pdma_pkg::*;
#(
  parameter int NCH = DEF_NCH,
  parameter int CHW = (NCH > 1) ? $clog2(NCH) : 1
)(
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  pdma_link_if.dev               lnk,
  output      logic              rx_out_valid,
  output      logic [DATA_W-1:0] rx_out_data,
  output      logic [CHW-1:0]    rx_out_chan,
  output      logic              rx_out_sop,
  output      logic              rx_out_eop,
  output      logic [NCH-1:0]    rx_enabled,
  output      logic              tx_fmt_valid,
  output      logic [CHW-1:0]    tx_fmt_chan,
  output      logic [HDR_W-1:0]  tx_fmt_hdr_words,
  output      logic [OFF_W-1:0]  tx_fmt_data_off
);

  typedef struct packed {
    logic [NCH-1:0]    en;
    logic [NCH-1:0]    td;
    logic [NCH-1:0]    pa;
    logic [NCH-1:0]    mono;
    logic [NCH-1:0]    inpkt;
    logic [NCH-1:0]    tdp;
    logic [NCH-1:0]    open;
    logic              ack;
    logic [DATA_W-1:0] rdata;
    logic              ov;
    logic [DATA_W-1:0] od;
    logic [CHW-1:0]    oc;
    logic              osop;
    logic              oeop;
    logic              fv;
    logic [CHW-1:0]    fc;
    logic [HDR_W-1:0]  fh;
    logic [OFF_W-1:0]  fo;
  } dev_s;

  dev_s st_r;
  dev_s st_nxt;

  logic                  take;
  logic [CHW-1:0]        rc;
  logic [WORD_SEL_W-1:0] rword;
  logic [ADDR_W-1:0]     rhi;
  logic                  rhit;
  logic                  rtx;

  assign take  = lnk.rxs_valid && st_r.open[lnk.rxs_chan];
  assign rc    = lnk.reg_addr[CH_SLOT_SHIFT +: CHW];
  assign rword = lnk.reg_addr[WORD_SEL_W-1:0];
  assign rtx   = lnk.reg_addr[TX_REGION_BIT];
  // Bits between the channel field and the region bit must be zero
  assign rhi   = ADDR_W'({1'b0, lnk.reg_addr[TX_REGION_BIT-1:0]}
                 >> (CH_SLOT_SHIFT + CHW));
  assign rhit  = (rhi == '0) && (int'(rc) < NCH);

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.ov  = take;
    st_nxt.fv  = 1'b0;

    // Stream beats and packet tracking
    if (take) begin
      st_nxt.od    = lnk.rxs_data;
      st_nxt.oc    = lnk.rxs_chan;
      st_nxt.osop  = lnk.rxs_sop;
      st_nxt.oeop  = lnk.rxs_eop;
      st_nxt.inpkt[lnk.rxs_chan] = !lnk.rxs_eop;
    end

    // Register access, one word per 32-byte slot
    if (lnk.reg_req) begin
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = REG_RESET;
      if (rhit && !rtx && rword == RX_RUN_OFF) begin
        if (lnk.reg_we) begin
          st_nxt.en[rc] = lnk.reg_wdata[RX_EN_BIT];
          st_nxt.td[rc] = lnk.reg_wdata[RX_TD_BIT];
          st_nxt.pa[rc] = lnk.reg_wdata[RX_PA_BIT];
        end else begin
          st_nxt.rdata[RX_EN_BIT] = st_r.en[rc];
          st_nxt.rdata[RX_TD_BIT] = st_r.td[rc];
          st_nxt.rdata[RX_PA_BIT] = st_r.pa[rc];
        end
      end else if (rhit && rtx && rword == TX_MODE_OFF) begin
        if (lnk.reg_we) begin
          st_nxt.mono[rc] = lnk.reg_wdata[TX_MONO_BIT];
        end else begin
          st_nxt.rdata[TX_MONO_BIT] = st_r.mono[rc];
        end
      end
    end

    if (lnk.td_req) begin
      st_nxt.tdp[lnk.td_chan] = 1'b1;
    end

    for (int i = 0; i < NCH; i++) begin
      // Teardown ends at a packet boundary; wins over a same-cycle write
      if (st_r.tdp[i] && !st_nxt.inpkt[i]) begin
        st_nxt.en[i]  = 1'b0;
        st_nxt.td[i]  = 1'b1;
        st_nxt.tdp[i] = 1'b0;
      end
      // Disable closes after this beat; pause and teardown wait for eop
      st_nxt.open[i] = st_nxt.en[i]
                       && ((!st_nxt.pa[i] && !st_nxt.tdp[i])
                           || st_nxt.inpkt[i]);
    end

    // Transmit monolithic header layout
    if (lnk.tx_desc_valid) begin
      st_nxt.fv = 1'b1;
      st_nxt.fc = lnk.tx_desc_chan;
      if (st_r.mono[lnk.tx_desc_chan]) begin
        st_nxt.fh = FIX_HDR_WORDS;
        st_nxt.fo = FIX_DATA_OFF;
      end else begin
        st_nxt.fh = NORM_HDR_WORDS;
        st_nxt.fo = lnk.tx_desc_off;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.reg_ack   = st_r.ack;
  assign lnk.reg_rdata = st_r.rdata;
  assign lnk.rx_open   = st_r.open;

  assign rx_out_valid     = st_r.ov;
  assign rx_out_data      = st_r.od;
  assign rx_out_chan      = st_r.oc;
  assign rx_out_sop       = st_r.osop;
  assign rx_out_eop       = st_r.oeop;
  assign rx_enabled       = st_r.en;
  assign tx_fmt_valid     = st_r.fv;
  assign tx_fmt_chan      = st_r.fc;
  assign tx_fmt_hdr_words = st_r.fh;
  assign tx_fmt_data_off  = st_r.fo;

endmodule

/* verif/pdma_link_properties.sv */
// Purpose: Assertions on the link between both packet_mover ends.
// Assumes: One clock, async active-low reset.
// Notes:   Watches the link signals only.
`timescale 1ns/1ps
module pdma_link_properties
  import pdma_pkg::*;
#(
  parameter int NCH = DEF_NCH,
  parameter int CHW = (NCH > 1) ? $clog2(NCH) : 1
)(
  input logic              clk_sys,
  input logic              resetn,
  input logic              reg_req,
  input logic              reg_we,
  input logic [ADDR_W-1:0] reg_addr,
  input logic [DATA_W-1:0] reg_wdata,
  input logic              reg_ack,
  input logic [DATA_W-1:0] reg_rdata,
  input logic              td_req,
  input logic [CHW-1:0]    td_chan,
  input logic              rxs_valid,
  input logic [DATA_W-1:0] rxs_data,
  input logic [CHW-1:0]    rxs_chan,
  input logic [NCH-1:0]    rx_open,
  input logic              tx_desc_valid,
  input logic [CHW-1:0]    tx_desc_chan,
  input logic [SIZE_W-1:0] tx_desc_size
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [NCH-1:0] mono_r;
  logic [CHW-1:0] td_ch_r;
  logic           wr1;
  assign wr1 = reg_req && reg_we && reg_addr == 12'h020;
  // Fixed-layout mirror per tx channel
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mono_r  <= '0;
      td_ch_r <= '0;
    end else begin
      if (reg_req && reg_we && reg_addr[11] && reg_addr[4:0] == TX_MODE_OFF)
        mono_r[reg_addr[5 +: CHW]] <= reg_wdata[TX_MONO_BIT];
      if (td_req)
        td_ch_r <= td_chan;
    end
  end
  property p_ack; reg_req |=> reg_ack; endproperty
  a_ack: assert property (p_ack)
    else $error("request not acked next cycle");
  property p_no_ack; !reg_req |=> !reg_ack; endproperty
  a_no_ack: assert property (p_no_ack)
    else $error("ack without request");
  property p_rsv;
    reg_req && !reg_we |=> reg_rdata[28:25] == '0 && reg_rdata[23:0] == '0
                           && (!reg_rdata[24] || $past(reg_addr[11]));
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits read nonzero");
  property p_open; wr1 && reg_wdata[31] && !reg_wdata[29] |=> rx_open[1];
  endproperty
  a_open: assert property (p_open)
    else $error("enabled channel not open");
  property p_close; wr1 && !reg_wdata[31] |=> !rx_open[1]; endproperty
  a_close: assert property (p_close)
    else $error("disabled channel still open");
  property p_td; td_req |=> ##[0:40] !rx_open[td_ch_r]; endproperty
  a_td: assert property (p_td)
    else $error("teardown did not close channel");
  property p_hold;
    rxs_valid && !rx_open[rxs_chan] |=> rxs_valid && $stable(rxs_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("refused beat not held");
  property p_size;
    tx_desc_valid && mono_r[tx_desc_chan] |-> tx_desc_size == 3'h3;
  endproperty
  a_size: assert property (p_size)
    else $error("fixed-layout push size wrong");
endmodule

/* verif/tb.sv */
// Purpose: Self-checking bench for both packet_mover ends.
// Assumes: 10 MHz clk_sys; tx channel kept idle except in the mode-hold test.
// Notes:   Drives the host end's user side only.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
  n_tests++; \
  if ((gt) !== (ex)) begin \
    err_total++; \
    $display("FAIL %s exp %0h got %0h", nm, ex, gt); \
  end \
end
module tb
  import pdma_pkg::*;
;
  localparam int CHW = $clog2(DEF_NCH);
  logic clk_sys, resetn, cmd_valid, tx_idle, cmd_ready, rsp_valid;
  logic src_valid, src_sop, src_eop, src_ready, tx_fmt_valid;
  logic rx_out_valid, rx_out_sop, rx_out_eop;
  cmd_op_e           cmd_op;
  logic [CHW-1:0]    cmd_chan, src_chan, rx_out_chan, tx_fmt_chan;
  logic [DATA_W-1:0] cmd_data, rsp_data, src_data, rx_out_data;
  logic [DATA_W-1:0] got_d, got_b;
  logic [DEF_NCH-1:0] rx_enabled;
  logic [HDR_W-1:0]  tx_fmt_hdr_words, hdr_q;
  logic [OFF_W-1:0]  tx_fmt_data_off, off_q;
  logic [CHW-1:0]    got_c, fc_q;
  logic [1:0]        got_se;
  int                err_total, n_tests, lat;
  int                beats = 0;

  pdma_link_if lnk ();
  pdma_rx_ctrl pdma_rx_ctrl_inst (.clk_sys, .resetn, .lnk(lnk.dev),
    .rx_out_valid, .rx_out_data, .rx_out_chan, .rx_out_sop, .rx_out_eop,
    .rx_enabled, .tx_fmt_valid, .tx_fmt_chan, .tx_fmt_hdr_words,
    .tx_fmt_data_off);
  pdma_host_end pdma_host_end_inst (.clk_sys, .resetn, .lnk(lnk.host),
    .cmd_valid, .cmd_op, .cmd_chan, .cmd_data, .tx_idle, .cmd_ready,
    .rsp_valid, .rsp_data, .src_valid, .src_data, .src_sop, .src_eop,
    .src_chan, .src_ready);
  pdma_link_properties #(.NCH(DEF_NCH)) pdma_link_properties_inst (
    .clk_sys, .resetn, .reg_req(lnk.reg_req), .reg_we(lnk.reg_we),
    .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata),
    .reg_ack(lnk.reg_ack), .reg_rdata(lnk.reg_rdata),
    .td_req(lnk.td_req), .td_chan(lnk.td_chan),
    .rxs_valid(lnk.rxs_valid), .rxs_data(lnk.rxs_data),
    .rxs_chan(lnk.rxs_chan), .rx_open(lnk.rx_open),
    .tx_desc_valid(lnk.tx_desc_valid), .tx_desc_chan(lnk.tx_desc_chan),
    .tx_desc_size(lnk.tx_desc_size));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (rx_out_valid === 1'b1) begin
      beats <= beats + 1;
      got_b <= rx_out_data;
      got_c <= rx_out_chan;
      got_se <= {rx_out_sop, rx_out_eop};
    end
    if (tx_fmt_valid === 1'b1) begin
      hdr_q <= tx_fmt_hdr_words;
      off_q <= tx_fmt_data_off;
      fc_q <= tx_fmt_chan;
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmd(input cmd_op_e op, input logic [CHW-1:0] ch,
                     input logic [DATA_W-1:0] d);
    int i;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_chan <= ch;
    cmd_data <= d;
    i = 0;
    // Valid stays up until the response; cmd_ready drops once the command is taken
    @(posedge clk_sys);
    while (rsp_valid !== 1'b1 && i < 60) begin
      @(posedge clk_sys);
      i++;
    end
    cmd_valid <= 1'b0;
    if (i >= 60) begin
      err_total++;
      give_verdict();
    end
    lat = i;
    got_d = rsp_data;
  endtask

  task automatic beat(input logic [DATA_W-1:0] d, input logic s,
                      input logic e);
    int i;
    src_valid <= 1'b1;
    src_data <= d;
    src_sop <= s;
    src_eop <= e;
    i = 0;
    @(posedge clk_sys);
    while (src_ready !== 1'b1 && i < 50) begin
      @(posedge clk_sys);
      i++;
    end
    src_valid <= 1'b0;
    if (i >= 50) begin
      err_total++;
      give_verdict();
    end
  endtask

  task automatic wait_beats(input int n);
    int i;
    i = 0;
    while (beats < n && i < 50) begin
      @(posedge clk_sys);
      i++;
    end
    if (i >= 50) begin
      err_total++;
      give_verdict();
    end
  endtask

  initial begin
    err_total = 0;
    n_tests = 0;
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_chan = '0;
    cmd_data = '0;
    tx_idle = 1'b1;
    src_valid = 1'b0;
    src_data = '0;
    src_sop = 1'b0;
    src_eop = 1'b0;
    src_chan = 3'h1;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    cmd(OP_READ, 3'h1, '0);
    `CHK("reset", 32'h0000_0000, got_d)
    cmd(OP_INIT, 3'h1, '0);
    cmd(OP_READ, 3'h1, '0);
    `CHK("init", 32'h8000_0000, got_d)
    `CHK("enabled", 8'h02, rx_enabled)
    cmd(OP_WRITE, 3'h1, 32'hbfff_ffff);
    cmd(OP_READ, 3'h1, '0);
    `CHK("reserved", 32'ha000_0000, got_d)
    $display("test init done");
    beat(32'h1234_5678, 1'b1, 1'b1);
    repeat (10) @(posedge clk_sys);
    `CHK("paused", 0, beats)
    cmd(OP_WRITE, 3'h1, 32'h8000_0000);
    wait_beats(1);
    `CHK("resumed", 1, beats)
    `CHK("beat", 32'h1234_5678, got_b)
    `CHK("beat_chan", 3'h1, got_c)
    `CHK("beat_ends", 2'b11, got_se)
    $display("test pause done");
    beat(32'h0000_00a1, 1'b1, 1'b0);
    wait_beats(2);
    cmd(OP_WRITE, 3'h1, 32'ha000_0000);
    beat(32'h0000_00a2, 1'b0, 1'b1);
    wait_beats(3);
    `CHK("pkt_end", 2'b01, got_se)
    beat(32'h0000_00a3, 1'b1, 1'b1);
    repeat (10) @(posedge clk_sys);
    `CHK("pkt_held", 3, beats)
    cmd(OP_WRITE, 3'h1, 32'h8000_0000);
    wait_beats(4);
    `CHK("pkt_resumed", 32'h0000_00a3, got_b)
    beat(32'h0000_00a4, 1'b1, 1'b0);
    wait_beats(5);
    // Disable issued mid-packet is held by the host until eop
    fork
      cmd(OP_WRITE, 3'h1, 32'h0000_0000);
      begin
        repeat (10) @(posedge clk_sys);
        beat(32'h0000_00a5, 1'b0, 1'b1);
      end
    join
    wait_beats(6);
    `CHK("no_loss", 32'h0000_00a5, got_b)
    `CHK("disabled", 8'h00, rx_enabled)
    $display("test packet done");
    cmd(OP_WRITE, 3'h1, 32'h8000_0000);
    cmd(OP_TEARDOWN, 3'h1, '0);
    repeat (2) @(posedge clk_sys);
    `CHK("td_en", 8'h00, rx_enabled)
    cmd(OP_READ, 3'h1, '0);
    `CHK("td_bit", 32'h4000_0000, got_d)
    cmd(OP_INIT, 3'h1, '0);
    cmd(OP_READ, 3'h1, '0);
    `CHK("reinit", 32'h8000_0000, got_d)
    $display("test teardown done");
    cmd(OP_TXMODE, 3'h2, 32'h0100_0000);
    cmd(OP_TXDESC, 3'h2, 32'h0000_0025);
    repeat (4) @(posedge clk_sys);
    `CHK("fix_hdr", 3'h4, hdr_q)
    `CHK("fix_off", 9'h010, off_q)
    `CHK("fix_chan", 3'h2, fc_q)
    cmd(OP_TXDESC, 3'h3, 32'h0000_0025);
    repeat (4) @(posedge clk_sys);
    `CHK("norm_hdr", 3'h3, hdr_q)
    `CHK("norm_off", 9'h025, off_q)
    `CHK("norm_chan", 3'h3, fc_q)
    // Mode write waits while the tx channel is busy
    tx_idle <= 1'b0;
    fork
      cmd(OP_TXMODE, 3'h3, 32'h0100_0000);
      begin
        repeat (10) @(posedge clk_sys);
        tx_idle <= 1'b1;
      end
    join
    `CHK("mode_held", 13, lat)
    cmd(OP_TXDESC, 3'h3, 32'h0000_0025);
    repeat (4) @(posedge clk_sys);
    `CHK("fix_hdr3", 3'h4, hdr_q)
    $display("test tx layout done");
    give_verdict();
  end
endmodule
